// File: core/pst_pin_sync.sv
// Two-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
module pst_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // One synchroniser and edge detector per pin
  for (genvar i = 0; i < W; i++)
  begin : g_pin
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        meta[i]  <= 1'b0;
        level[i] <= 1'b0;
        prev[i]  <= 1'b0;
      end
      else
      begin
        meta[i]  <= pin_in[i];
        level[i] <= meta[i];
        prev[i]  <= level[i];
      end
    end
    assign fall[i] = prev[i] & ~level[i];
    assign rise[i] = ~prev[i] & level[i];
  end
endmodule // pst_pin_sync

// File: core/pst_pkg.sv
// Constants and types of the power-up sequence timer
// Operation
// [RL1] Select-pin falling edge starts sequence when selected
// [RL2] Otherwise data-pin falling edge starts, if separate
// [RL3] Reset: start select 1, delay 0, window 10
// [RL4] Delay codes 0-6 wait 32 to 256 ticks
// [RL5] Delay code 7 powers receiver at lock
// [RL6] Window codes 0-14 wait 20 to 64 ticks
// [RL7] Window code 15 waits 72 filter ticks
// [RL8] Block-reset bits return to one at start
// [RL9] Sub-block reset completes only with clock running
// [RL10] Host polls completion status until all ones
// [RL11] Pin starts only in power-down mode three
// [RL12] Force power down returns to waiting idle
// [RL13] Sequencer reset bit low forces idle
// [RL14] Start edge during sequence is ignored
package pst_pkg;
  // Word indices; byte address is four times the index
  localparam logic [9:0] PST_IDX_CTRL  = 10'h000;
  localparam logic [9:0] PST_IDX_BLK   = 10'h002;
  localparam logic [9:0] PST_IDX_SEQ   = 10'h003;
  localparam logic [9:0] PST_IDX_STAT  = 10'h010;
  localparam logic [9:0] PST_IDX_MASK  = 10'h011;
  localparam logic [9:0] PST_IDX_STATE = 10'h012;
  localparam logic [9:0] PST_IDX_DONE  = 10'h041;
  // Control register fields
  localparam int PST_C_RUN  = 0;
  localparam int PST_C_FPD  = 1;
  localparam int PST_C_SEP  = 2;
  localparam int PST_C_MODE = 4;
  localparam logic [7:0] PST_CTRL_RST = 8'h01;
  localparam logic [1:0] PST_MODE_SEQ = 2'h3;
  // Sequencing register fields
  localparam int PST_S_PSEL = 7;
  localparam int PST_S_RXW  = 4;
  localparam int PST_S_CSW  = 0;
  localparam logic [7:0] PST_SEQ_RST  = 8'h8A;
  localparam logic [2:0] PST_RXW_NONE = 3'h7;
  // Wait tables in converter and filter clock periods
  localparam logic [6:0][8:0] PST_RXW_TBL = {9'h100, 9'h0B0, 9'h080,
    9'h058, 9'h040, 9'h02C, 9'h020};
  localparam logic [15:0][6:0] PST_CS_TBL = {7'h48, 7'h40, 7'h3C, 7'h38,
    7'h34, 7'h30, 7'h2C, 7'h28, 7'h24, 7'h20, 7'h1E, 7'h1C, 7'h1A,
    7'h18, 7'h16, 7'h14};
  // Block reset bits and their reset value
  localparam int PST_BR_SEQ = 1;
  localparam logic [7:0] PST_BLK_ONES = 8'hFF;
  // Interrupt status bits
  localparam int PST_IRQ_W = 5;
  localparam int PST_I_START = 0;
  localparam int PST_I_RXUP  = 1;
  localparam int PST_I_TOUT  = 2;
  localparam int PST_I_CARR  = 3;
  localparam int PST_I_RDONE = 4;
  // Synchronised pin positions
  localparam int PST_NPIN  = 6;
  localparam int PST_P_SEL = 0;
  localparam int PST_P_DIO = 1;
  localparam int PST_P_LCK = 2;
  localparam int PST_P_CS  = 3;
  localparam int PST_P_ADC = 4;
  localparam int PST_P_FLT = 5;
  typedef enum logic [4:0] {
    PST_IDLE    = 5'b00001,
    PST_LOCK    = 5'b00010,
    PST_RXWAIT  = 5'b00100,
    PST_CSWAIT  = 5'b01000,
    PST_CARRIER = 5'b10000
  } pst_state_e;
endpackage

// File: core/pst_seq_fsm.sv
// Power-up sequencing engine with wait counters
`timescale 1ns/1ps
module pst_seq_fsm (
  input wire logic sys_clk,
  input wire logic rstn,
  pst_seq_if.seq   sq
);
  import pst_pkg::*;
  pst_state_e state;
  pst_state_e next_state;
  logic [8:0] cnt;

  // Next state; start ignored outside idle
  always_comb
  begin
    next_state = state;
    if (sq.clr || sq.force_pd)
      next_state = PST_IDLE;
    else
      unique case (state)
        PST_IDLE:    if (sq.start) next_state = PST_LOCK; // [RL14]
        PST_LOCK:    if (sq.lock)
                       next_state = (sq.rx_wait == PST_RXW_NONE) ?
                                    PST_CSWAIT : PST_RXWAIT; // [RL5]
        PST_RXWAIT:  if (sq.adc_tick && cnt == 9'h001)
                       next_state = PST_CSWAIT; // [RL4]
        PST_CSWAIT:  if (sq.carrier) next_state = PST_CARRIER;
                     else if (sq.flt_tick && cnt == 9'h001)
                       next_state = PST_IDLE; // [RL6]
        PST_CARRIER: next_state = PST_CARRIER; // Carrier holds receiver on
      endcase
  end

  // State and power enables
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state       <= PST_IDLE;
      sq.synth_en <= 1'b0;
      sq.rx_en    <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      sq.synth_en <= next_state != PST_IDLE;
      sq.rx_en    <= next_state inside {PST_CSWAIT, PST_CARRIER};
    end
  end

  // Wait counter loaded from the tables
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= 9'h000;
    else if (next_state == PST_RXWAIT && state == PST_LOCK)
      cnt <= PST_RXW_TBL[sq.rx_wait]; // [RL4]
    else if (next_state == PST_CSWAIT && state != PST_CSWAIT)
      cnt <= {2'h0, PST_CS_TBL[sq.cs_wait]}; // [RL6] [RL7]
    else if ((state == PST_RXWAIT && sq.adc_tick) ||
             (state == PST_CSWAIT && sq.flt_tick))
      cnt <= cnt - 9'h001;
  end

  // Event pulses
  assign sq.state    = state;
  assign sq.ev_start = state == PST_IDLE && next_state == PST_LOCK;
  assign sq.ev_rxup  = state != PST_CSWAIT && next_state == PST_CSWAIT;
  assign sq.ev_tout  = state == PST_CSWAIT && next_state == PST_IDLE &&
                       !sq.clr && !sq.force_pd;
  assign sq.ev_carr  = state == PST_CSWAIT && next_state == PST_CARRIER;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_rx_nowait;
    state == PST_LOCK && sq.lock && sq.rx_wait == PST_RXW_NONE &&
    !sq.clr && !sq.force_pd |=> state == PST_CSWAIT && sq.rx_en;
  endproperty
  a_rx_nowait: assert property (p_rx_nowait) // [RL5]
    else $error("receiver not powered at lock");

  property p_rx_load;
    state == PST_LOCK && sq.lock && sq.rx_wait != PST_RXW_NONE &&
    !sq.clr && !sq.force_pd
    |=> cnt == PST_RXW_TBL[$past(sq.rx_wait)] && !sq.rx_en;
  endproperty
  a_rx_load: assert property (p_rx_load) // [RL4]
    else $error("wrong lock to receive delay");

  property p_cs_load;
    state == PST_RXWAIT && sq.adc_tick && cnt == 9'h001 &&
    !sq.clr && !sq.force_pd
    |=> cnt == {2'h0, PST_CS_TBL[$past(sq.cs_wait)]} && sq.rx_en;
  endproperty
  a_cs_load: assert property (p_cs_load) // [RL6]
    else $error("wrong carrier sense window");

  property p_cs_max;
    state == PST_RXWAIT && sq.adc_tick && cnt == 9'h001 &&
    !sq.clr && !sq.force_pd && sq.cs_wait == 4'hF |=> cnt == 9'h048;
  endproperty
  a_cs_max: assert property (p_cs_max) // [RL7]
    else $error("window code 15 not 72 periods");

  property p_ignore;
    state == PST_RXWAIT && sq.start && !sq.adc_tick &&
    !sq.clr && !sq.force_pd |=> state == PST_RXWAIT && $stable(cnt);
  endproperty
  a_ignore: assert property (p_ignore) // [RL14]
    else $error("start disturbed running sequence");
endmodule // pst_seq_fsm

// File: core/pst_seq_if.sv
// Link between register front end and sequencing engine
`timescale 1ns/1ps
interface pst_seq_if;
  import pst_pkg::*;
  logic       start, force_pd, clr, lock, carrier, adc_tick, flt_tick;
  logic [2:0] rx_wait;
  logic [3:0] cs_wait;
  logic       synth_en, rx_en, ev_start, ev_rxup, ev_tout, ev_carr;
  pst_state_e state;
  modport ctrl (output start, force_pd, clr, lock, carrier, adc_tick,
    flt_tick, rx_wait, cs_wait, input synth_en, rx_en, ev_start,
    ev_rxup, ev_tout, ev_carr, state);
  modport seq (input start, force_pd, clr, lock, carrier, adc_tick,
    flt_tick, rx_wait, cs_wait, output synth_en, rx_en, ev_start,
    ev_rxup, ev_tout, ev_carr, state);
endinterface

// File: core/pst_top.sv
// Power-up sequence timer with AHB-Lite register slave
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module pst_top (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        select_pin,
  input  wire logic        data_io_pin,
  input  wire logic        synth_lock,
  input  wire logic        carrier_sense,
  input  wire logic        adc_clk,
  input  wire logic        filter_clk,
  input  wire logic [7:0]  clk_running,
  output logic             synth_en,
  output logic             rx_en,
  output logic [7:0]       sub_reset_n,
  output logic             irq
);
  import pst_pkg::*;

  pst_seq_if sq ();

  logic [PST_NPIN-1:0]  pin_lvl;
  logic [PST_NPIN-1:0]  pin_fall;
  logic [PST_NPIN-1:0]  pin_rise;
  logic [7:0]           run_s;
  logic                 acc;
  logic                 rd_pend;
  logic                 wr_pend;
  logic [9:0]           dp_idx;
  logic [9:0]           rd_idx;
  logic                 wr_ctrl;
  logic                 wr_seq;
  logic                 wr_blk;
  logic                 wr_stat;
  logic                 wr_mask;
  logic                 start_on_select_pin;
  logic [2:0]           rx_wait;
  logic [3:0]           cs_wait;
  logic                 sequencer_reset_low;
  logic                 force_power_down;
  logic                 separate_rx_output;
  logic [1:0]           power_down_mode_select;
  logic [7:0]           blk_req;
  logic [7:0]           next_done;
  logic [PST_IRQ_W-1:0] ev;
  logic [PST_IRQ_W-1:0] stat;
  logic [PST_IRQ_W-1:0] next_stat;
  logic [PST_IRQ_W-1:0] mask;
  logic [31:0]          rd_mux;
  logic                 pin_mode;

  // Pins and clocks from outside this domain
  pst_pin_sync #(.W(PST_NPIN)) u_pins (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_in  ({filter_clk, adc_clk, carrier_sense, synth_lock,
               data_io_pin, select_pin}),
    .level   (pin_lvl),
    .fall    (pin_fall),
    .rise    (pin_rise)
  );

  pst_pin_sync #(.W(8)) u_run (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_in  (clk_running),
    .level   (run_s),
    .fall    (),
    .rise    ()
  );

  pst_seq_fsm u_fsm (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sq      (sq.seq)
  );

  // Bus address phase accepted
  assign acc = hsel && htrans[1] && hready;

  // Bus phase tracking; reads take one wait state
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_pend   <= 1'b0;
      wr_pend   <= 1'b0;
      dp_idx    <= 10'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      rd_pend   <= acc && !hwrite;
      wr_pend   <= acc && hwrite;
      hreadyout <= !(acc && !hwrite);
      hresp     <= 1'b0;
      if (acc)
        dp_idx <= haddr[11:2];
    end
  end
  assign rd_idx = dp_idx;

  // Write strobes in the data phase
  assign wr_ctrl = wr_pend && dp_idx == PST_IDX_CTRL;
  assign wr_seq  = wr_pend && dp_idx == PST_IDX_SEQ;
  assign wr_blk  = wr_pend && dp_idx == PST_IDX_BLK;
  assign wr_stat = wr_pend && dp_idx == PST_IDX_STAT;
  assign wr_mask = wr_pend && dp_idx == PST_IDX_MASK;

  // Sequencing register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_on_select_pin <= PST_SEQ_RST[PST_S_PSEL]; // [RL3]
      rx_wait             <= PST_SEQ_RST[PST_S_RXW +: 3];
      cs_wait             <= PST_SEQ_RST[PST_S_CSW +: 4];
    end
    else if (wr_seq)
    begin
      start_on_select_pin <= hwdata[PST_S_PSEL];
      rx_wait             <= hwdata[PST_S_RXW +: 3];
      cs_wait             <= hwdata[PST_S_CSW +: 4];
    end
  end

  // Control register; force bit is a write pulse
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sequencer_reset_low    <= PST_CTRL_RST[PST_C_RUN];
      separate_rx_output     <= PST_CTRL_RST[PST_C_SEP];
      power_down_mode_select <= PST_CTRL_RST[PST_C_MODE +: 2];
      force_power_down       <= 1'b0;
    end
    else
    begin
      force_power_down <= wr_ctrl && hwdata[PST_C_FPD]; // [RL12]
      if (wr_ctrl)
      begin
        sequencer_reset_low    <= hwdata[PST_C_RUN];
        separate_rx_output     <= hwdata[PST_C_SEP];
        power_down_mode_select <= hwdata[PST_C_MODE +: 2];
      end
    end
  end

  // Block reset: writing 0 starts, clock running completes
  assign blk_req   = wr_blk ? ~hwdata[7:0] : 8'h00;
  assign next_done = (sub_reset_n | run_s) & ~blk_req; // [RL8] [RL9]

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sub_reset_n <= PST_BLK_ONES;
    else
      sub_reset_n <= next_done;
  end

  // Start sources into the sequencing engine
  assign pin_mode   = power_down_mode_select == PST_MODE_SEQ; // [RL11]
  assign sq.start   = pin_mode &&
    (start_on_select_pin ? pin_fall[PST_P_SEL] // [RL1]
     : separate_rx_output && pin_fall[PST_P_DIO]); // [RL2]
  assign sq.force_pd = force_power_down; // [RL12]
  assign sq.clr     = !sequencer_reset_low || // [RL13]
                      !sub_reset_n[PST_BR_SEQ];
  assign sq.lock     = pin_lvl[PST_P_LCK];
  assign sq.carrier  = pin_lvl[PST_P_CS];
  assign sq.adc_tick = pin_rise[PST_P_ADC];
  assign sq.flt_tick = pin_rise[PST_P_FLT];
  assign sq.rx_wait  = rx_wait;
  assign sq.cs_wait  = cs_wait;
  assign synth_en    = sq.synth_en;
  assign rx_en       = sq.rx_en;

  // Sticky status, write one to clear, set wins
  assign ev[PST_I_START] = sq.ev_start;
  assign ev[PST_I_RXUP]  = sq.ev_rxup;
  assign ev[PST_I_TOUT]  = sq.ev_tout;
  assign ev[PST_I_CARR]  = sq.ev_carr;
  assign ev[PST_I_RDONE] = |(~sub_reset_n & next_done);
  assign next_stat = (stat & ~(wr_stat ? hwdata[PST_IRQ_W-1:0]
                     : {PST_IRQ_W{1'b0}})) | ev;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat <= '0;
      mask <= '0;
      irq  <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      if (wr_mask)
        mask <= hwdata[PST_IRQ_W-1:0];
      irq <= |(next_stat & (wr_mask ? hwdata[PST_IRQ_W-1:0] : mask));
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (rd_idx)
      PST_IDX_CTRL:  rd_mux = {26'h0, power_down_mode_select, 1'b0,
                               separate_rx_output, 1'b0,
                               sequencer_reset_low};
      PST_IDX_SEQ:   rd_mux = {24'h0, start_on_select_pin, rx_wait,
                               cs_wait};
      PST_IDX_BLK:   rd_mux = {24'h0, PST_BLK_ONES}; // [RL8]
      PST_IDX_DONE:  rd_mux = {24'h0, sub_reset_n};
      PST_IDX_STAT:  rd_mux = {27'h0, stat};
      PST_IDX_MASK:  rd_mux = {27'h0, mask};
      PST_IDX_STATE: rd_mux = {25'h0, sq.synth_en, sq.rx_en, sq.state};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (rd_pend)
      hrdata <= rd_mux;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_psel;
    sq.state == PST_IDLE && pin_fall[PST_P_SEL] && start_on_select_pin
    && pin_mode && !sq.clr && !sq.force_pd
    |=> sq.state == PST_LOCK ##1 synth_en;
  endproperty
  a_psel: assert property (p_psel) // [RL1]
    else $error("select pin edge did not start");

  property p_dio;
    sq.state == PST_IDLE && !start_on_select_pin && !pin_fall[PST_P_DIO]
    |=> sq.state == PST_IDLE;
  endproperty
  a_dio: assert property (p_dio) // [RL2]
    else $error("start without data pin edge");

  property p_dio_go;
    sq.state == PST_IDLE && !start_on_select_pin && separate_rx_output
    && pin_mode && pin_fall[PST_P_DIO] && !sq.clr && !sq.force_pd
    |=> sq.state == PST_LOCK;
  endproperty
  a_dio_go: assert property (p_dio_go) // [RL2]
    else $error("data pin edge did not start");

  property p_rst_val;
    $past(!rstn) |-> {start_on_select_pin, rx_wait, cs_wait}
                     == PST_SEQ_RST;
  endproperty
  a_rst_val: assert property (p_rst_val) // [RL3]
    else $error("sequencing reset value wrong");

  property p_blk_set;
    wr_blk |=> ($past(blk_req) & sub_reset_n) == 8'h00;
  endproperty
  a_blk_set: assert property (p_blk_set) // [RL8]
    else $error("block reset request lost");

  property p_blk_hold;
    1'b1 |=> ($past(~sub_reset_n & ~run_s) & sub_reset_n) == 8'h00;
  endproperty
  a_blk_hold: assert property (p_blk_hold) // [RL9]
    else $error("reset completed with clock stopped");

  property p_mode;
    sq.state == PST_IDLE && !pin_mode |=> sq.state == PST_IDLE [*2];
  endproperty
  a_mode: assert property (p_mode) // [RL11]
    else $error("pin start outside mode three");

  property p_fpd;
    wr_ctrl && hwdata[PST_C_FPD]
    |=> ##1 sq.state == PST_IDLE ##1 !synth_en && !rx_en;
  endproperty
  a_fpd: assert property (p_fpd) // [RL12]
    else $error("force power down ignored");

  property p_seqrst;
    !sequencer_reset_low |=> sq.state == PST_IDLE && !rx_en;
  endproperty
  a_seqrst: assert property (p_seqrst) // [RL13]
    else $error("sequencer reset ignored");
endmodule // pst_top

// File: testbench/powerup_sequence_timer_test.sv
// Self-checking bench for the power-up sequence timer
`timescale 1ns/1ps
module powerup_sequence_timer_test;
  import pst_pkg::*;
  typedef struct {string nm; logic [9:0] idx; logic [31:0] e;} pst_row_s;
  logic        sys_clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
  logic        select_pin, data_io_pin, synth_lock, carrier_sense;
  logic        adc_clk, filter_clk, synth_en, rx_en;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  clk_running, sub_reset_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          fails, checks_done, adc_cnt, flt_cnt, n;
  int          rxw [8] = '{32, 44, 64, 88, 128, 176, 256, 0};
  pst_row_s    rows [7] = '{'{"ctrl", PST_IDX_CTRL, 32'h01},
    '{"seq", PST_IDX_SEQ, 32'h8A}, '{"blk", PST_IDX_BLK, 32'hFF},
    '{"stat", PST_IDX_STAT, 32'h00}, '{"mask", PST_IDX_MASK, 32'h00},
    '{"state", PST_IDX_STATE, 32'h01}, '{"none", 10'h3F0, 32'h00}};

  // Clock at 50 MHz
  always #10 sys_clk = ~sys_clk;

  pst_top uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .select_pin(select_pin), .data_io_pin(data_io_pin),
    .synth_lock(synth_lock), .carrier_sense(carrier_sense),
    .adc_clk(adc_clk), .filter_clk(filter_clk), .clk_running(clk_running),
    .synth_en(synth_en), .rx_en(rx_en), .sub_reset_n(sub_reset_n),
    .irq(irq));

  pst_partner radio (.sys_clk(sys_clk), .rstn(rstn), .synth_en(synth_en),
    .rx_en(rx_en), .adc_clk(adc_clk), .filter_clk(filter_clk),
    .synth_lock(synth_lock), .adc_cnt(adc_cnt), .flt_cnt(flt_cnt));

  // Verdict and end of run
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task timeout;
    fails++;
    conclude;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task chk_rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi)
    begin
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      fails++;
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Wait for hready sampled high at a rising edge
  task rdy;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && k < 50)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 50)
      timeout;
  endtask

  // One AHB-Lite single transfer: address phase, then data phase
  task bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    haddr <= {20'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, q);
  endtask

  // Falling edge on the select pin or, with sel set, the data pin
  task pulse(input logic sel);
    @(posedge sys_clk);
    if (sel)
      data_io_pin <= 1'b0;
    else
      select_pin <= 1'b0;
    tick(6);
    select_pin <= 1'b1;
    data_io_pin <= 1'b1;
  endtask

  // Bounded wait for rx_en (sel set) or synth_en to reach v
  task wait_on(input logic sel, input logic v);
    int k;
    k = 0;
    while ((sel ? rx_en : synth_en) !== v && k < 3000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 3000)
      timeout;
  endtask

  function automatic int cs_exp(input int c);
    return c < 7 ? 20 + 2 * c : c == 7 ? 36 : c < 15 ? 8 + 4 * c : 72;
  endfunction

  // Main sequence
  initial
  begin
    {sys_clk, rstn, htrans, haddr, hwrite, hwdata, carrier_sense} = '0;
    {hsel, select_pin, data_io_pin} = 3'b111;
    hsize = 3'h2;
    clk_running = 8'hFF;
    fails = 0;
    checks_done = 0;
    tick(8);
    rstn <= 1'b1;
    chk("irq", 1'b0, irq);
    foreach (rows[i])
      rd_chk(rows[i].nm, rows[i].idx, rows[i].e);
    // Interrupt masked, then unmasked; forced power down
    wr(PST_IDX_CTRL, 32'h31);
    pulse(1'b0);
    wait_on(1'b0, 1'b1);
    chk("irq masked", 1'b0, irq);
    wr(PST_IDX_MASK, 32'h1F);
    tick(2);
    chk("irq", 1'b1, irq);
    wr(PST_IDX_CTRL, 32'h33);
    tick(2);
    chk("synth_en", 1'b0, synth_en);
    wr(PST_IDX_STAT, 32'h1F);
    tick(2);
    chk("irq cleared", 1'b0, irq);
    pulse(1'b0);
    wait_on(1'b0, 1'b1);
    wr(PST_IDX_CTRL, 32'h33);
    wr(PST_IDX_STAT, 32'h1F);
    // Every window code, every delay code, second start mid-sequence
    for (int i = 0; i < 16; i++)
    begin
      wr(PST_IDX_SEQ, 32'h80 | ((i % 8) << 4) | i);
      pulse(1'b0);
      wait_on(1'b0, 1'b1);
      tick(20);
      pulse(1'b0);
      wait_on(1'b1, 1'b1);
      chk_rng("rx wait", rxw[i%8], rxw[i%8] + 2, adc_cnt);
      wait_on(1'b1, 1'b0);
      chk_rng("cs wait", cs_exp(i) - 1, cs_exp(i) + 1, flt_cnt);
      chk("synth_en", 1'b0, synth_en);
      rd_chk("stat", PST_IDX_STAT, 32'h07);
      chk("irq", 1'b1, irq);
      wr(PST_IDX_STAT, 32'h1F);
    end
    // Carrier keeps receiver on; sequencer reset bit clears it
    carrier_sense <= 1'b1;
    wr(PST_IDX_SEQ, 32'hF0);
    pulse(1'b0);
    wait_on(1'b1, 1'b1);
    tick(240);
    chk("rx_en", 1'b1, rx_en);
    rd_chk("stat", PST_IDX_STAT, 32'h0B);
    wr(PST_IDX_CTRL, 32'h30);
    tick(3);
    chk("rx_en", 1'b0, rx_en | synth_en);
    pulse(1'b0);
    tick(20);
    chk("synth_en", 1'b0, synth_en);
    carrier_sense <= 1'b0;
    wr(PST_IDX_CTRL, 32'h01);
    pulse(1'b0);
    tick(20);
    chk("synth_en", 1'b0, synth_en);
    // Data pin starts only with the select pin deselected and separate set
    wr(PST_IDX_CTRL, 32'h31);
    wr(PST_IDX_SEQ, 32'h0A);
    pulse(1'b0);
    tick(20);
    chk("synth_en", 1'b0, synth_en);
    pulse(1'b1);
    tick(20);
    chk("synth_en", 1'b0, synth_en);
    wr(PST_IDX_CTRL, 32'h35);
    pulse(1'b1);
    wait_on(1'b0, 1'b1);
    wr(PST_IDX_CTRL, 32'h37);
    wr(PST_IDX_STAT, 32'h1F);
    // Block reset pending while its clock is stopped
    clk_running <= 8'hF7;
    wr(PST_IDX_BLK, 32'hF7);
    rd_chk("blk", PST_IDX_BLK, 32'hFF);
    tick(10);
    chk("sub_reset_n", 8'hF7, sub_reset_n);
    rd_chk("done", PST_IDX_DONE, 32'hF7);
    clk_running <= 8'hFF;
    n = 0;
    q = 32'h0;
    while (q !== 32'hFF && n < 20)
    begin
      bus(1'b0, PST_IDX_DONE, 32'h0);
      n++;
    end
    chk("done", 32'hFF, q);
    rd_chk("stat", PST_IDX_STAT, 32'h10);
    chk("hresp", 1'b0, hresp);
    // Sequencer block reset mid-sequence, then a reset mid-sequence
    pulse(1'b1);
    wait_on(1'b0, 1'b1);
    wr(PST_IDX_BLK, 32'hFD);
    tick(2);
    chk("synth_en", 1'b0, synth_en);
    pulse(1'b1);
    wait_on(1'b0, 1'b1);
    rstn <= 1'b0;
    tick(2);
    chk("reset outputs", 1'b0, synth_en | rx_en | irq);
    rstn <= 1'b1;
    rd_chk("seq", PST_IDX_SEQ, 32'h8A);
    rd_chk("ctrl", PST_IDX_CTRL, 32'h01);
    conclude;
  end
endmodule // powerup_sequence_timer_test

// File: testbench/pst_partner.sv
// Model of the radio side: converter and filter clocks, synth lock
`timescale 1ns/1ps
module pst_partner (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic synth_en,
  input  wire logic rx_en,
  output logic      adc_clk,
  output logic      filter_clk,
  output logic      synth_lock,
  output int        adc_cnt,
  output int        flt_cnt
);
  logic [2:0] ph;
  logic [2:0] dly;
  // Free-running phase, both clocks at one eighth of sys_clk
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ph <= 3'h0;
    else
      ph <= ph + 3'h1;
  end
  assign adc_clk = ph[2];
  assign filter_clk = ph[2] ^ ph[1];
  // Lock comes five cycles after power up, lost at power down
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      dly <= 3'h0;
    else if (!synth_en)
      dly <= 3'h0;
    else if (dly != 3'h5)
      dly <= dly + 3'h1;
  end
  assign synth_lock = (dly == 3'h5);
  // Rising edges from lock to receiver power up, and since power up
  always_ff @(posedge sys_clk)
  begin
    adc_cnt <= !synth_lock ? 0 : adc_cnt + int'(ph == 3'h3 && !rx_en);
    flt_cnt <= !rx_en ? 0 : flt_cnt + int'(ph == 3'h1);
  end
endmodule // pst_partner
